// file: mal_regs.svh
// register offsets, field positions and reset values of the arithmetic datapath
// Notes on behaviour
// - pointer add: sign-extend 6-bit literal, add to chosen pair, flags untouched
// - pointer sum wraps modulo 65536 at both ends of the range
// - and_immediate: W and literal into W, only zero flag changes
// - add_immediate: W plus literal into W, updates carry, digit carry, zero
// - and_file: W and byte, destination bit routes result, only zero changes
// - add_file: W plus byte, routed by destination bit, updates C, DC, Z
// - shift right: bit 7 kept, bit 0 to carry, routed, updates C and Z
// - add_file_with_carry: W plus byte plus carry, routed, updates C, DC, Z
`ifndef MAL_REGS_SVH
`define MAL_REGS_SVH
`define MAL_OFF_ISSUE 12'h000
`define MAL_OFF_WREG 12'h004
`define MAL_OFF_STATUS 12'h008
`define MAL_OFF_PTR0 12'h00C
`define MAL_OFF_PTR1 12'h010
`define MAL_OFF_COUNT 12'h014
`define MAL_DMEM_WIN 3'h1
`define MAL_ISS_OP_MSB 2
`define MAL_ISS_OP_LSB 0
`define MAL_ISS_DEST 3
`define MAL_ISS_PTR 4
`define MAL_ISS_LIT_MSB 15
`define MAL_ISS_LIT_LSB 8
`define MAL_ISS_FADDR_MSB 22
`define MAL_ISS_FADDR_LSB 16
`define MAL_ISS_PEND 31
`define MAL_ST_C 0
`define MAL_ST_DC 1
`define MAL_ST_Z 2
`define MAL_RST_WREG 8'h00
`define MAL_RST_PTR 16'h0000
`define MAL_RST_FLAGS 3'h0
`define MAL_RST_COUNT 16'h0000
`endif

// file: mal_pkg.sv
// types and shared arithmetic of the arithmetic datapath
package mal_pkg;
    typedef enum logic [2:0] {
        MAL_NOP = 3'b000,
        MAL_ADD_IMMEDIATE = 3'b001,
        MAL_AND_IMMEDIATE = 3'b010,
        MAL_ADD_FILE = 3'b011,
        MAL_AND_FILE = 3'b100,
        MAL_ADD_FILE_WITH_CARRY = 3'b101,
        MAL_ARITH_SHIFT_RIGHT_FILE = 3'b110,
        MAL_POINTER_ADD_LITERAL = 3'b111
    } mal_op_t;
    typedef enum logic [1:0] {
        MAL_ST_IDLE = 2'b00,
        MAL_ST_WR = 2'b01,
        MAL_ST_RD_WAIT = 2'b10,
        MAL_ST_RD_OUT = 2'b11
    } mal_bus_st_t;
    typedef struct packed {
        mal_op_t op;
        logic dest;
        logic ptr_sel;
        logic [7:0] lit;
        logic [6:0] faddr;
    } mal_ins_t;
    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } mal_flags_t;
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } mal_bus_t;
    // returns {carry7, carry3, sum}
    function automatic logic [9:0] mal_add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {full[8], lo[4], full[7:0]};
    endfunction
    function automatic logic mal_is_file(input mal_op_t op);
        return op inside {MAL_ADD_FILE, MAL_AND_FILE, MAL_ADD_FILE_WITH_CARRY, MAL_ARITH_SHIFT_RIGHT_FILE};
    endfunction
endpackage

// file: mal_alu.sv
// combinational arithmetic unit: byte ops, flags and pointer sum
`timescale 1ns/1ps
module mal_alu import mal_pkg::*; (
    input mal_ins_t ins,
    input logic [7:0] w,
    input logic [7:0] f,
    input logic [15:0] ptr,
    input mal_flags_t fl_in,
    output mal_flags_t fl_out,
    output logic [7:0] result,
    output logic [15:0] ptr_sum
);
    logic [9:0] sum;

    // byte result and flag update per operation
    always_comb begin
        sum = 10'h000;
        result = w;
        fl_out = fl_in;
        case (ins.op)
            MAL_ADD_IMMEDIATE: sum = mal_add8(w, ins.lit, 1'b0);
            MAL_ADD_FILE: sum = mal_add8(w, f, 1'b0);
            MAL_ADD_FILE_WITH_CARRY: sum = mal_add8(w, f, fl_in.c);
            default: sum = 10'h000;
        endcase
        case (ins.op)
            MAL_ADD_IMMEDIATE, MAL_ADD_FILE, MAL_ADD_FILE_WITH_CARRY: begin
                result = sum[7:0];
                fl_out.c = sum[9];
                fl_out.dc = sum[8];
            end
            MAL_AND_IMMEDIATE: result = w & ins.lit;
            MAL_AND_FILE: result = w & f;
            MAL_ARITH_SHIFT_RIGHT_FILE: begin
                result = {f[7], f[7:1]};
                fl_out.c = f[0];
            end
            default: result = w;
        endcase
        // pointer add and idle slots leave every flag alone
        if (ins.op != MAL_NOP && ins.op != MAL_POINTER_ADD_LITERAL) begin
            fl_out.z = (result == 8'h00);
        end
    end

    // 16-bit sum drops the carry, so it wraps both ways
    assign ptr_sum = ptr + {{10{ins.lit[5]}}, ins.lit[5:0]};

endmodule // mal_alu

// file: mal_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module mal_ahb_slave import mal_pkg::*; (
    input logic hclk,
    input logic hresetn,
    input logic ce,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic hready,
    input logic [31:0] hwdata,
    input logic [31:0] rdata_in,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output mal_bus_t bus
);
    mal_bus_st_t st_r;
    logic [11:0] addr_r;
    logic accept;

    // only whole-word transfers are expected, so hsize is not decoded
    assign accept = ce && hsel && htrans[1] && hready;
    // the read wait lets a write in the previous data phase land first
    assign hreadyout = ce && (st_r != MAL_ST_RD_WAIT);
    assign hresp = 1'b0;
    assign bus.wr = ce && (st_r == MAL_ST_WR);
    assign bus.addr = addr_r;
    assign bus.wdata = hwdata;

    // transfer phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= MAL_ST_IDLE;
            addr_r <= 12'h000;
        end else if (ce) begin
            case (st_r)
                MAL_ST_RD_WAIT: st_r <= MAL_ST_RD_OUT;
                default: begin
                    if (accept) begin
                        st_r <= hwrite ? MAL_ST_WR : MAL_ST_RD_WAIT;
                        addr_r <= {haddr[11:2], 2'b00};
                    end else begin
                        st_r <= MAL_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // read data captured after any earlier write took effect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && st_r == MAL_ST_RD_WAIT) begin
            hrdata <= rdata_in;
        end
    end

    wire unused_size = ^hsize;

endmodule // mal_ahb_slave

// file: mal_core.sv
// arithmetic datapath top: W, flags, pointer pairs, data memory, register bus
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "mal_regs.svh"
module mal_core import mal_pkg::*; (
    input logic hclk,
    input logic hresetn,
    input logic ce,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic hready,
    input logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input logic dec_valid,
    input mal_ins_t dec_ins,
    output logic [7:0] wreg_out,
    output mal_flags_t flags_out
);
    mal_bus_t bus;
    logic [31:0] rdata;
    logic [7:0] w_r;
    mal_flags_t fl_r;
    logic [15:0] ptr_r [2];
    logic [7:0] mem_r [128];
    mal_ins_t sw_ins_r;
    logic sw_pend_r;
    logic [15:0] count_r;
    mal_ins_t ins;
    logic fire;
    logic [7:0] fval;
    logic [7:0] result;
    mal_flags_t fl_nxt;
    logic [15:0] ptr_nxt;
    logic wr_w;
    logic wr_f;
    logic wr_p;
    logic bus_mem;

    mal_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .rdata_in(rdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .bus(bus)
    );

    mal_alu u_alu (
        .ins(ins),
        .w(w_r),
        .f(fval),
        .ptr(ptr_r[ins.ptr_sel]),
        .fl_in(fl_r),
        .fl_out(fl_nxt),
        .result(result),
        .ptr_sum(ptr_nxt)
    );

    // decoder has priority; a software issue waits behind it
    assign fire = ce && (dec_valid || sw_pend_r);
    assign ins = dec_valid ? dec_ins : sw_ins_r;
    assign fval = mem_r[ins.faddr];

    // destination routing
    assign wr_f = fire && mal_is_file(ins.op) && ins.dest;
    assign wr_w = fire && (ins.op == MAL_ADD_IMMEDIATE || ins.op == MAL_AND_IMMEDIATE
        || (mal_is_file(ins.op) && !ins.dest));
    assign wr_p = fire && ins.op == MAL_POINTER_ADD_LITERAL;
    assign bus_mem = bus.addr[11:9] == `MAL_DMEM_WIN;

    assign wreg_out = w_r;
    assign flags_out = fl_r;

    // register read mux, unmapped words read zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (bus_mem) begin
            rdata[7:0] = mem_r[bus.addr[8:2]];
        end else begin
            case (bus.addr)
                `MAL_OFF_ISSUE: rdata = {sw_pend_r, 8'h00, sw_ins_r.faddr, sw_ins_r.lit, 3'h0,
                    sw_ins_r.ptr_sel, sw_ins_r.dest, sw_ins_r.op};
                `MAL_OFF_WREG: rdata[7:0] = w_r;
                `MAL_OFF_STATUS: rdata[2:0] = fl_r;
                `MAL_OFF_PTR0: rdata[15:0] = ptr_r[0];
                `MAL_OFF_PTR1: rdata[15:0] = ptr_r[1];
                `MAL_OFF_COUNT: rdata[15:0] = count_r;
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    // working register; execution wins over a bus write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_r <= `MAL_RST_WREG;
        end else if (ce) begin
            if (bus.wr && bus.addr == `MAL_OFF_WREG) begin
                w_r <= bus.wdata[7:0];
            end
            if (wr_w) begin
                w_r <= result;
            end
        end
    end

    // status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fl_r <= `MAL_RST_FLAGS;
        end else if (ce) begin
            if (bus.wr && bus.addr == `MAL_OFF_STATUS) begin
                fl_r <= bus.wdata[`MAL_ST_Z:`MAL_ST_C];
            end
            if (fire) begin
                fl_r <= fl_nxt;
            end
        end
    end

    // pointer pairs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_r[0] <= `MAL_RST_PTR;
            ptr_r[1] <= `MAL_RST_PTR;
        end else if (ce) begin
            if (bus.wr && bus.addr == `MAL_OFF_PTR0) begin
                ptr_r[0] <= bus.wdata[15:0];
            end
            if (bus.wr && bus.addr == `MAL_OFF_PTR1) begin
                ptr_r[1] <= bus.wdata[15:0];
            end
            if (wr_p) begin
                ptr_r[ins.ptr_sel] <= ptr_nxt;
            end
        end
    end

    // data memory, no reset: contents are undefined at power-up
    always_ff @(posedge hclk) begin
        if (ce) begin
            if (bus.wr && bus_mem) begin
                mem_r[bus.addr[8:2]] <= bus.wdata[7:0];
            end
            if (wr_f) begin
                mem_r[ins.faddr] <= result;
            end
        end
    end

    // software issue slot; a new issue beats the clear of the old one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_pend_r <= 1'b0;
            sw_ins_r <= '0;
        end else if (ce) begin
            if (sw_pend_r && !dec_valid) begin
                sw_pend_r <= 1'b0;
            end
            if (bus.wr && bus.addr == `MAL_OFF_ISSUE) begin
                sw_pend_r <= 1'b1;
                sw_ins_r.op <= mal_op_t'(bus.wdata[`MAL_ISS_OP_MSB:`MAL_ISS_OP_LSB]);
                sw_ins_r.dest <= bus.wdata[`MAL_ISS_DEST];
                sw_ins_r.ptr_sel <= bus.wdata[`MAL_ISS_PTR];
                sw_ins_r.lit <= bus.wdata[`MAL_ISS_LIT_MSB:`MAL_ISS_LIT_LSB];
                sw_ins_r.faddr <= bus.wdata[`MAL_ISS_FADDR_MSB:`MAL_ISS_FADDR_LSB];
            end
        end
    end

    // executed-operation counter, wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= `MAL_RST_COUNT;
        end else if (fire) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // checks on the datapath
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_ptr_add_sum: assert property (
        wr_p |=> ptr_r[$past(ins.ptr_sel)] == 16'($past(ptr_r[ins.ptr_sel])
            + {{10{$past(ins.lit[5])}}, $past(ins.lit[5:0])}) && fl_r == $past(fl_r))
        else $error("pointer add sum or flags wrong");

    a_ptr_wrap_top: assert property (
        wr_p && ptr_r[ins.ptr_sel] == 16'hFFFF && ins.lit[5:0] == 6'h01
            |=> ptr_r[$past(ins.ptr_sel)] == 16'h0000)
        else $error("pointer did not wrap at top");

    a_and_imm_w: assert property (
        fire && ins.op == MAL_AND_IMMEDIATE |=> w_r == ($past(w_r) & $past(ins.lit))
            && fl_r.c == $past(fl_r.c) && fl_r.dc == $past(fl_r.dc))
        else $error("and immediate result or flags wrong");

    a_add_imm_w: assert property (
        fire && ins.op == MAL_ADD_IMMEDIATE
            |=> {fl_r.c, w_r} == {1'b0, $past(w_r)} + {1'b0, $past(ins.lit)})
        else $error("add immediate sum or carry wrong");

    a_and_file_route: assert property (
        fire && ins.op == MAL_AND_FILE && ins.dest
            |=> mem_r[$past(ins.faddr)] == ($past(w_r) & $past(fval)) && fl_r.c == $past(fl_r.c))
        else $error("and file result not in memory");

    a_add_file_route: assert property (
        fire && ins.op == MAL_ADD_FILE && !ins.dest
            |=> {fl_r.c, w_r} == {1'b0, $past(w_r)} + {1'b0, $past(fval)})
        else $error("add file result not in working register");

    a_shift_right: assert property (
        fire && ins.op == MAL_ARITH_SHIFT_RIGHT_FILE && ins.dest
            |=> mem_r[$past(ins.faddr)] == {$past(fval[7]), $past(fval[7:1])}
            && fl_r.c == $past(fval[0]) && fl_r.dc == $past(fl_r.dc))
        else $error("shift right result or carry wrong");

    a_add_carry_in: assert property (
        fire && ins.op == MAL_ADD_FILE_WITH_CARRY && !ins.dest
            |=> {fl_r.c, w_r} == {1'b0, $past(w_r)} + {1'b0, $past(fval)} + {8'h00, $past(fl_r.c)})
        else $error("add with carry sum wrong");

    a_zero_flag: assert property (
        wr_w |=> fl_r.z == (w_r == 8'h00))
        else $error("zero flag does not match result");

    a_digit_carry: assert property (
        fire && ins.op == MAL_ADD_IMMEDIATE
            |=> fl_r.dc == (({1'b0, $past(w_r[3:0])} + {1'b0, $past(ins.lit[3:0])}) > 5'h0F))
        else $error("digit carry wrong");

    a_ptr_wrap_bottom: assert property (
        wr_p && ptr_r[ins.ptr_sel] == 16'h0000 && ins.lit[5:0] == 6'h20
            |=> ptr_r[$past(ins.ptr_sel)] == 16'hFFE0)
        else $error("pointer did not wrap at bottom");

    a_ptr_pair_kept: assert property (
        wr_p && !bus.wr |=> ptr_r[~$past(ins.ptr_sel)] == $past(ptr_r[~ins.ptr_sel]))
        else $error("pointer add touched the other pair");

    // the byte ops with the destination not covered above
    a_and_file_w: assert property (
        fire && ins.op == MAL_AND_FILE && !ins.dest
            |=> w_r == ($past(w_r) & $past(fval)) && fl_r.dc == $past(fl_r.dc))
        else $error("and file result not in working register");

    a_add_file_mem: assert property (
        fire && ins.op == MAL_ADD_FILE && ins.dest
            |=> {fl_r.c, mem_r[$past(ins.faddr)]} == {1'b0, $past(w_r)} + {1'b0, $past(fval)})
        else $error("add file result not in memory");

    a_shift_w: assert property (
        fire && ins.op == MAL_ARITH_SHIFT_RIGHT_FILE && !ins.dest
            |=> w_r == {$past(fval[7]), $past(fval[7:1])} && fl_r.c == $past(fval[0]))
        else $error("shift right result not in working register");

    a_addc_mem: assert property (
        fire && ins.op == MAL_ADD_FILE_WITH_CARRY && ins.dest
            |=> {fl_r.c, mem_r[$past(ins.faddr)]}
            == {1'b0, $past(w_r)} + {1'b0, $past(fval)} + {8'h00, $past(fl_r.c)})
        else $error("add with carry result not in memory");

    a_zero_file: assert property (
        wr_f |=> fl_r.z == (mem_r[$past(ins.faddr)] == 8'h00))
        else $error("zero flag does not match stored byte");

    // nothing moves without an operation or a bus write, ce low included
    a_idle_frozen: assert property (
        !fire && !bus.wr |=> w_r == $past(w_r) && fl_r == $past(fl_r) && count_r == $past(count_r))
        else $error("state moved while idle");

    a_count_step: assert property (
        fire |=> count_r == $past(count_r) + 16'h0001)
        else $error("operation count did not step");

    // a read always costs one wait so a preceding write lands first
    a_read_wait: assert property (
        ce && hsel && htrans[1] && hready && !hwrite |=> !hreadyout)
        else $error("read answered without its wait state");

    c_ptr_wrap: cover property (wr_p && ins.lit[5] && ptr_r[ins.ptr_sel] == 16'h0000);
    c_carry_in: cover property (fire && ins.op == MAL_ADD_FILE_WITH_CARRY && fl_r.c);
    c_file_dest: cover property (wr_f ##1 fire);
    c_sw_issue: cover property (sw_pend_r && !dec_valid && ce);
    c_nop: cover property (fire && ins.op == MAL_NOP);

endmodule // mal_core

// file: mal_dec_model.sv
// decoder-side partner model: drives the decode port one instruction at a time
`timescale 1ns/1ps
module mal_dec_model import mal_pkg::*; (
    input wire logic hclk,
    output logic dec_valid,
    output mal_ins_t dec_ins
);
    // quiet port until the first request
    initial begin
        dec_valid = 1'b0;
        dec_ins = '0;
    end
    // caller sits just after a rising edge; hold keeps valid up for a back-to-back op
    task automatic send(input mal_ins_t ins, input bit hold);
        dec_ins <= ins;
        dec_valid <= 1'b1;
        @(posedge hclk);
        if (!hold) begin
            dec_valid <= 1'b0;
            dec_ins <= ~ins; // released lines must not look like the last op
        end
    endtask
endmodule // mal_dec_model

// file: mal_core_tb_top.sv
// self-checking bench for the arithmetic datapath top
`timescale 1ns/1ps
`include "mal_regs.svh"
module mal_core_tb_top import mal_pkg::*;;
    logic hclk, hresetn, ce, hsel, hwrite, dec_valid, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] wreg_out, sw;
    logic [7:0] smem [128];
    logic [15:0] sptr [2];
    logic [15:0] scnt;
    mal_flags_t flags_out, sfl;
    mal_ins_t dec_ins;
    int errors, check_count;

    mal_core u_mal_core (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dec_valid(dec_valid),
        .dec_ins(dec_ins), .wreg_out(wreg_out), .flags_out(flags_out));
    mal_dec_model u_mal_dec_model (.hclk(hclk), .dec_valid(dec_valid), .dec_ins(dec_ins));

    // 250 MHz core clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // looks at hready just before the edge, so the edge itself is never raced
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 64) begin
            n++;
            @(negedge hclk);
        end
        if (hreadyout !== 1'b1) begin
            errors++;
            conclude();
        end
        @(posedge hclk);
    endtask

    // one single ahb transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
        htrans <= 2'b10;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(nm, e, rd);
    endtask

    task automatic setw(input logic [7:0] v);
        wr(`MAL_OFF_WREG, {24'h00_0000, v});
        sw = v;
    endtask

    task automatic setfl(input mal_flags_t v);
        wr(`MAL_OFF_STATUS, {29'h0000_0000, v});
        sfl = v;
    endtask

    task automatic setm(input logic [6:0] a, input logic [7:0] v);
        wr({3'b001, a, 2'b00}, {24'h00_0000, v});
        smem[a] = v;
    endtask

    task automatic setp(input logic p, input logic [15:0] v);
        wr(p ? `MAL_OFF_PTR1 : `MAL_OFF_PTR0, {16'h0000, v});
        sptr[p] = v;
    endtask

    function automatic mal_ins_t mk(input mal_op_t o, input logic d, input logic p, input logic [7:0] l,
        input logic [6:0] f);
        mk = '{o, d, p, l, f};
    endfunction

    function automatic logic [9:0] radd(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] l;
        s = a + b + ci;
        l = a[3:0] + b[3:0] + ci;
        return {s[8], l[4], s[7:0]};
    endfunction

    // reference behaviour of one executed instruction
    task automatic exec(input mal_ins_t i);
        logic [7:0] m, r;
        logic [9:0] s;
        m = smem[i.faddr];
        r = 8'h00;
        scnt++;
        case (i.op)
            MAL_ADD_IMMEDIATE, MAL_ADD_FILE, MAL_ADD_FILE_WITH_CARRY: begin
                s = radd(sw, i.op == MAL_ADD_IMMEDIATE ? i.lit : m, i.op == MAL_ADD_FILE_WITH_CARRY && sfl.c);
                r = s[7:0];
                sfl.c = s[9];
                sfl.dc = s[8];
            end
            MAL_AND_IMMEDIATE: r = sw & i.lit;
            MAL_AND_FILE: r = sw & m;
            MAL_ARITH_SHIFT_RIGHT_FILE: begin
                r = {m[7], m[7:1]};
                sfl.c = m[0];
            end
            MAL_POINTER_ADD_LITERAL: sptr[i.ptr_sel] += {{10{i.lit[5]}}, i.lit[5:0]};
            default: ;
        endcase
        if (i.op != MAL_NOP && i.op != MAL_POINTER_ADD_LITERAL) begin
            sfl.z = (r == 8'h00);
            if (i.op inside {MAL_ADD_IMMEDIATE, MAL_AND_IMMEDIATE} || !i.dest)
                sw = r;
            else
                smem[i.faddr] = r;
        end
    endtask

    // results show the cycle after the op is taken
    task automatic verify(input mal_ins_t i);
        @(negedge hclk);
        chk("wreg", {24'h00_0000, sw}, {24'h00_0000, wreg_out});
        chk("flags", {29'h0000_0000, sfl}, {29'h0000_0000, flags_out});
        @(posedge hclk);
        rdchk("file", {3'b001, i.faddr, 2'b00}, {24'h00_0000, smem[i.faddr]});
        rdchk("ptr", i.ptr_sel ? `MAL_OFF_PTR1 : `MAL_OFF_PTR0, {16'h0000, sptr[i.ptr_sel]});
    endtask

    task automatic run(input mal_ins_t i);
        u_mal_dec_model.send(i, 1'b0);
        exec(i);
        verify(i);
    endtask

    task automatic t_reset();
        chk("wreg_rst", 32'h0000_0000, {24'h00_0000, wreg_out});
        rdchk("status_rst", `MAL_OFF_STATUS, 32'h0000_0000);
        rdchk("ptr0_rst", `MAL_OFF_PTR0, 32'h0000_0000);
        rdchk("ptr1_rst", `MAL_OFF_PTR1, 32'h0000_0000);
        rdchk("count_rst", `MAL_OFF_COUNT, 32'h0000_0000);
        rdchk("issue_rst", `MAL_OFF_ISSUE, 32'h0000_0000);
        chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
        wr(12'h100, 32'hFFFF_FFFF);
        rdchk("unmapped", 12'h100, 32'h0000_0000);
        for (int a = 0; a < 128; a++)
            setm(7'(a), 8'(a) ^ 8'h5A);
        rdchk("mem_top", 12'h3FC, 32'h0000_0025);
        $display("test reset done");
    endtask

    task automatic t_imm();
        setw(8'h8F);
        run(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h71, 7'h00));
        run(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h08, 7'h00));
        u_mal_dec_model.send(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h08, 7'h00), 1'b1);
        u_mal_dec_model.send(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'hF8, 7'h00), 1'b0);
        exec(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h08, 7'h00));
        exec(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'hF8, 7'h00));
        verify(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'hF8, 7'h00));
        setfl(3'b011);
        setw(8'hF0);
        run(mk(MAL_AND_IMMEDIATE, 1'b0, 1'b0, 8'h0F, 7'h00));
        setw(8'hA5);
        run(mk(MAL_AND_IMMEDIATE, 1'b0, 1'b0, 8'h3C, 7'h00));
        $display("test immediate done");
    endtask

    task automatic t_file();
        for (int d = 0; d < 2; d++) begin
            setw(8'hC3);
            run(mk(MAL_ADD_FILE, d[0], 1'b0, 8'h00, 7'h7F));
            run(mk(MAL_AND_FILE, d[0], 1'b0, 8'h00, 7'h00));
            setfl(3'b001);
            run(mk(MAL_ADD_FILE_WITH_CARRY, d[0], 1'b0, 8'h00, 7'h40));
            setw(8'hFF);
            setm(7'h03, 8'h00);
            setfl(3'b001);
            run(mk(MAL_ADD_FILE_WITH_CARRY, d[0], 1'b0, 8'h00, 7'h03));
        end
        setm(7'h05, 8'h81);
        run(mk(MAL_ARITH_SHIFT_RIGHT_FILE, 1'b1, 1'b0, 8'h00, 7'h05));
        setm(7'h06, 8'h01);
        run(mk(MAL_ARITH_SHIFT_RIGHT_FILE, 1'b0, 1'b0, 8'h00, 7'h06));
        run(mk(MAL_ARITH_SHIFT_RIGHT_FILE, 1'b1, 1'b0, 8'h00, 7'h7E));
        $display("test file done");
    endtask

    task automatic t_ptr();
        setfl(3'b111);
        setp(1'b0, 16'hFFFF);
        run(mk(MAL_POINTER_ADD_LITERAL, 1'b0, 1'b0, 8'h01, 7'h00));
        setp(1'b1, 16'h0000);
        run(mk(MAL_POINTER_ADD_LITERAL, 1'b0, 1'b1, 8'h20, 7'h00));
        run(mk(MAL_POINTER_ADD_LITERAL, 1'b0, 1'b1, 8'hDF, 7'h00));
        $display("test pointer done");
    endtask

    task automatic t_issue();
        ce <= 1'b0;
        u_mal_dec_model.send(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h01, 7'h00), 1'b0);
        ce <= 1'b1;
        verify(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h01, 7'h00));
        setw(8'h3C);
        wr(`MAL_OFF_ISSUE, {9'h000, 7'h00, 8'h0F, 3'b000, 1'b0, 1'b0, MAL_AND_IMMEDIATE});
        @(posedge hclk);
        exec(mk(MAL_AND_IMMEDIATE, 1'b0, 1'b0, 8'h0F, 7'h00));
        verify(mk(MAL_AND_IMMEDIATE, 1'b0, 1'b0, 8'h0F, 7'h00));
        rdchk("issue", `MAL_OFF_ISSUE, 32'h0000_0F02);
        run(mk(MAL_NOP, 1'b0, 1'b0, 8'h00, 7'h00));
        rdchk("count", `MAL_OFF_COUNT, {16'h0000, scnt});
        $display("test issue done");
    endtask

    // reset pulled in mid-run: registers return to reset values, memory keeps its bytes
    task automatic t_midrst();
        setw(8'h77);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        sw = 8'h00;
        sfl = '0;
        sptr[0] = 16'h0000;
        sptr[1] = 16'h0000;
        scnt = 16'h0000;
        @(posedge hclk);
        chk("wreg_midrst", 32'h0000_0000, {24'h00_0000, wreg_out});
        rdchk("count_midrst", `MAL_OFF_COUNT, 32'h0000_0000);
        rdchk("issue_midrst", `MAL_OFF_ISSUE, 32'h0000_0000);
        run(mk(MAL_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h05, 7'h10));
        $display("test midrun reset done");
    endtask

    // watchdog against a hang anywhere
    initial begin
        repeat (50000) @(posedge hclk);
        errors++;
        conclude();
    end

    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        errors = 0;
        check_count = 0;
        sw = 8'h00;
        sfl = '0;
        sptr[0] = 16'h0000;
        sptr[1] = 16'h0000;
        scnt = 16'h0000;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_imm();
        t_file();
        t_ptr();
        t_issue();
        t_midrst();
        conclude();
    end
endmodule // mal_core_tb_top
